// file: hw/fjs_map.svh
`ifndef FJS_MAP_SVH
`define FJS_MAP_SVH
// attempts allowed to bring a sheet to the edge sensor
`define FJS_MAX_TRIES 2'd3
// timing figures in microseconds
`define FJS_LIFT_US 2000000
`define FJS_PICK_US 500000
`define FJS_PULSE_US 100000
`define FJS_LONG_US 3000000
`define FJS_STALL_US 2500000
`define FJS_CLK_MHZ 100
`define FJS_CYC(us) ((us) * `FJS_CLK_MHZ)
// timer bit that toggles the motor while freeing a sheet
`define FJS_PULSE_BIT 4
`endif

// file: hw/fjs_pkg.sv
package fjs_pkg;
   typedef struct packed {
      logic tray;
      logic edge_seen;
      logic door_open;
      logic plate_up;
   } fjs_sense_s;
   typedef struct packed {
      logic feed_motor;
      logic lift_up;
      logic lift_down;
      logic capture;
   } fjs_drive_s;
   typedef struct packed {
      logic mispick;
      logic jam;
      logic busy;
   } fjs_stat_s;
   typedef enum logic [2:0] {
      FJS_IDLE = 3'b000,
      FJS_LIFT = 3'b001,
      FJS_PICK = 3'b010,
      FJS_FREE = 3'b011,
      FJS_FEED = 3'b100,
      FJS_HOME = 3'b101
   } fjs_state_e;
endpackage

// file: hw/fjs_sync.sv
`timescale 1ns/1ps
module fjs_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         meta <= '0;
         q_o <= '0;
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // fjs_sync

// file: hw/fjs_top.sv
`timescale 1ns/1ps
`include "fjs_map.svh"
// Behaviour
// RULE1: tray sensor means documents are loaded
// RULE2: edge sensor gives leading and trailing edges
// RULE3: door sensor input watched for open door
// RULE4: start command with paper begins pick
// RULE5: failed pick pulses motor, cycles lift plate
// RULE6: three failed attempts raise mispick error
// RULE7: no trailing edge within long time jams
// RULE8: sheet not clearing in expected time jams
// RULE9: jam stops feed, lowers plate, reports
// RULE10: open door inhibits all feeder operation
// RULE11: raise plate to roller before picking
// RULE12: leading edge starts image capture
// RULE13: keep feeding while tray reports paper
// RULE14: timeout limits are configurable cycle counts
// RULE15: separate sticky mispick and jam flags
module fjs_top #(
   parameter int unsigned LIFT_CYC = `FJS_CYC(`FJS_LIFT_US),
   parameter int unsigned PICK_CYC = `FJS_CYC(`FJS_PICK_US),
   parameter int unsigned PULSE_CYC = `FJS_CYC(`FJS_PULSE_US),
   parameter int unsigned LONG_CYC = `FJS_CYC(`FJS_LONG_US),
   parameter int unsigned STALL_CYC = `FJS_CYC(`FJS_STALL_US)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // sensor pins
   input wire fjs_pkg::fjs_sense_s sense_i,
   // user interface
   input wire logic start_i,
   input wire logic clear_i,
   // actuators and status
   output fjs_pkg::fjs_drive_s drive_o,
   output fjs_pkg::fjs_stat_s stat_o
);
   import fjs_pkg::*;

   fjs_sense_s s;
   fjs_state_e state;
   fjs_state_e next_state;
   logic [31:0] timer;
   logic [1:0] tries;
   logic edge_q;
   logic lead;
   logic trail;
   logic tmo_pick;
   logic tmo_feed;
   logic tmo_lift;
   logic tmo_pulse;
   logic set_mis;
   logic set_jam;
   logic mispick;
   logic jam;
   logic busy;
   logic motor_on;
   logic plate_raise;
   logic plate_lower;
   logic capture_on;

   // outputs are plain wiring from the flops below
   assign stat_o = {mispick, jam, busy};
   assign drive_o = {motor_on, plate_raise, plate_lower, capture_on};

   fjs_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i(sense_i),
      .q_o(s)
   );

   assign lead = s.edge_seen && !edge_q; // see RULE2
   assign trail = !s.edge_seen && edge_q; // see RULE2
   assign tmo_lift = timer >= LIFT_CYC;
   assign tmo_pick = timer >= PICK_CYC;
   assign tmo_pulse = timer >= PULSE_CYC;
   // a sheet longer than the limit never clears; a stalled one never moves
   assign tmo_feed = timer >= LONG_CYC || timer >= STALL_CYC; // see RULE7 see RULE8 see RULE14

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         edge_q <= 1'b0;
      else
         edge_q <= s.edge_seen;
   end

   always_comb
   begin
      next_state = state;
      set_mis = 1'b0;
      set_jam = 1'b0;
      case (state)
         FJS_IDLE:
            if (start_i && s.tray && !jam && !mispick) // see RULE1 see RULE4
               next_state = FJS_LIFT;
         FJS_LIFT:
            if (s.plate_up) // see RULE11
               next_state = FJS_PICK;
            else if (tmo_lift)
            begin
               set_mis = 1'b1;
               next_state = FJS_HOME;
            end
         FJS_PICK:
            if (lead)
               next_state = FJS_FEED;
            else if (tmo_pick)
            begin
               if (tries >= `FJS_MAX_TRIES - 2'd1) // see RULE6
               begin
                  set_mis = 1'b1;
                  next_state = FJS_HOME;
               end
               else
                  next_state = FJS_FREE; // see RULE5
            end
         FJS_FREE:
            if (tmo_pulse)
               next_state = FJS_LIFT;
         FJS_FEED:
            if (trail)
               next_state = s.tray ? FJS_PICK : FJS_HOME; // see RULE13
            else if (tmo_feed)
            begin
               set_jam = 1'b1;
               next_state = FJS_HOME;
            end
         FJS_HOME:
            if (tmo_pulse)
               next_state = FJS_IDLE;
         default:
            next_state = FJS_IDLE;
      endcase
      // an open door parks the machine, a start from idle is dropped too
      if (s.door_open) // see RULE3 see RULE10
      begin
         next_state = FJS_IDLE;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         state <= FJS_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         timer <= 32'h0;
      else if (next_state != state)
         timer <= 32'h0;
      else if (timer != 32'hffffffff)
         timer <= timer + 32'h1;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         tries <= 2'h0;
      else if (state == FJS_PICK && next_state == FJS_FREE)
         tries <= tries + 2'h1; // see RULE6
      else if (state == FJS_FEED || state == FJS_IDLE)
         tries <= 2'h0;
   end

   // sticky error flags; a new error wins over a clear
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         mispick <= 1'b0;
      else
         mispick <= set_mis || (mispick && !clear_i); // see RULE15
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         jam <= 1'b0;
      else
         jam <= set_jam || (jam && !clear_i); // see RULE15 see RULE9
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         busy <= 1'b0;
      else
         busy <= next_state != FJS_IDLE;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         motor_on <= 1'b0;
      else
         motor_on <= next_state == FJS_PICK || next_state == FJS_FEED
            || (next_state == FJS_FREE && timer[`FJS_PULSE_BIT]); // see RULE5 see RULE9
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         plate_raise <= 1'b0;
      else
         plate_raise <= next_state == FJS_LIFT; // see RULE11
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         plate_lower <= 1'b0;
      else
         plate_lower <= next_state == FJS_FREE || next_state == FJS_HOME; // see RULE9
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         capture_on <= 1'b0;
      else
         capture_on <= next_state == FJS_FEED; // see RULE12
   end
endmodule // fjs_top

// file: tb/fjs_chk.sv
`timescale 1ns/1ps
module fjs_chk #(
   parameter int STALL_CYC = 150
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // watched ports
   input wire fjs_pkg::fjs_sense_s sense_i,
   input wire logic start_i,
   input wire logic clear_i,
   input wire fjs_pkg::fjs_drive_s drive_o,
   input wire fjs_pkg::fjs_stat_s stat_o
);
   localparam int CAP_MAX = STALL_CYC + 10;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   door_off_a: assert property (sense_i.door_open [*5] |-> drive_o == 4'h0)
      else $error("door");
   start_busy_a: assert property ($rose(stat_o.busy) |-> $past(start_i))
      else $error("start");
   idle_quiet_a: assert property (!stat_o.busy |-> drive_o == 4'h0)
      else $error("idle");
   jam_stop_a: assert property ($rose(stat_o.jam) |-> ##[0:1] (drive_o.lift_down && !drive_o.feed_motor))
      else $error("jam stop");
   jam_hold_a: assert property (stat_o.jam && !clear_i |=> stat_o.jam)
      else $error("jam");
   mis_hold_a: assert property (stat_o.mispick && !clear_i |=> stat_o.mispick)
      else $error("mispick");
   plate_first_a: assert property ($rose(drive_o.feed_motor) && !drive_o.lift_down |-> $past(sense_i.plate_up, 2))
      else $error("plate");
   cap_edge_a: assert property ($rose(drive_o.capture) |-> $past(sense_i.edge_seen, 3))
      else $error("capture");
   cap_bound_a: assert property ($rose(drive_o.capture) |-> ##[1:CAP_MAX] !drive_o.capture)
      else $error("stall");
   cover property ($rose(stat_o.jam));
   cover property ($rose(stat_o.mispick));
   cover property (sense_i.door_open [*5] ##0 stat_o.busy == 1'b0);
endmodule // fjs_chk
bind fjs_top fjs_chk #(.STALL_CYC(STALL_CYC)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .sense_i(sense_i), .start_i(start_i), .clear_i(clear_i), .drive_o(drive_o), .stat_o(stat_o));

// file: tb/fjs_feed.sv
`timescale 1ns/1ps
module fjs_feed (
   // clock
   input wire logic clk_i,
   // actuators and test controls
   input wire fjs_pkg::fjs_drive_s drive_i,
   input wire logic [2:0] load_i,
   input wire logic [1:0] mode_i,
   input wire logic door_i,
   // sensors
   output fjs_pkg::fjs_sense_s sense_o
);
   int lift = 0;
   int run = 0;
   int n = 0;
   always @(posedge clk_i)
   begin
      if (drive_i.lift_down) lift <= 0;
      else if (drive_i.lift_up) lift <= lift + 1;
      if (load_i != 3'h0) n <= int'(load_i);
      else if (run == 40 && mode_i == 2'h0) n <= n - 1;
      if (!drive_i.feed_motor || !sense_o.plate_up || n == 0 || mode_i == 2'h1) run <= 0;
      else if (run == 40 && mode_i == 2'h0) run <= 0;
      else run <= run + 1;
   end
   assign sense_o = {n > 0, run >= 10, door_i, lift >= 10};
endmodule // fjs_feed

// file: tb/test_fjs_top.sv
`timescale 1ns/1ps
module test_fjs_top;
   import fjs_pkg::*;
   logic clk_i = 0;
   logic sys_rst_i = 1;
   logic start_i = 0;
   logic clear_i = 0;
   logic door = 0;
   logic [2:0] load = 0;
   logic [2:0] k;
   logic [1:0] mode = 0;
   logic [31:0] seed = 32'h5aa9cc4f;
   fjs_sense_s sense;
   fjs_drive_s drive;
   fjs_stat_s stat;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   int caps = 0;
   int lifts = 0;
   int cap0 = 0;
   int lift0 = 0;
   fjs_top #(.LIFT_CYC(50), .PICK_CYC(40), .PULSE_CYC(20), .LONG_CYC(200), .STALL_CYC(150)) uut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sense_i(sense), .start_i(start_i),
      .clear_i(clear_i), .drive_o(drive), .stat_o(stat));
   fjs_feed far (.clk_i(clk_i), .drive_i(drive), .load_i(load), .mode_i(mode),
      .door_i(door), .sense_o(sense));
   initial forever #5 clk_i = ~clk_i;
   task print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      caps <= caps + int'($rose(drive.capture));
      lifts <= lifts + int'($rose(drive.lift_up));
      if (cyc == 20000)
      begin
         miscompares++;
         print_verdict;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask
   task tick(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask
   task job(input logic [1:0] m, input logic [2:0] s, input int stop);
      mode = m;
      load = s;
      tick(1);
      load = 0;
      tick(3);
      cap0 = caps;
      lift0 = lifts;
      start_i = 1;
      tick(1);
      start_i = 0;
      for (int i = 0; i < 3000 && (stat.busy === 1'b1 || i < 2) && i < stop; i++) tick(1);
      if (stop >= 3000)
         chk("finish", stat.busy, 1'h0);
   endtask
   initial
   begin
      tick(2);
      sys_rst_i = 0;
      chk("drive", drive, 4'h0);
      for (int i = 0; i < 2; i++)
      begin
         k = 3'(rnd() % 4 + 1);
         job(0, k, 3000);
         chk("sheets", caps - cap0, k);
         chk("stat", stat, 3'h0);
      end
      job(1, 2, 3000);
      chk("tries", lifts - lift0, 32'h3);
      chk("stat", stat, 3'h4);
      job(0, 2, 3000);
      chk("refused", caps - cap0, 32'h0);
      clear_i = 1;
      tick(1);
      clear_i = 0;
      job(2, 1, 3000);
      chk("stat", stat, 3'h2);
      clear_i = 1;
      tick(1);
      clear_i = 0;
      job(0, 3, 30);
      door = 1;
      tick(6);
      chk("door", {drive, stat}, 7'h0);
      start_i = 1;
      tick(1);
      start_i = 0;
      chk("door start", {drive, stat}, 7'h0);
      door = 0;
      print_verdict;
   end
endmodule // test_fjs_top
